// >>> rtl/itcsb_pkg.sv
package itcsb_pkg;

    // ==========================================================
    // Command codes
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7c;
    localparam logic [7:0] CMD_THERMAL_STATUS = 8'h7d;
    localparam logic [7:0] CMD_CML_STATUS = 8'h7e;

    // ==========================================================
    // Supported bit masks and field positions
    localparam logic [7:0] INPUT_LATCH_MASK = 8'he0;
    localparam logic [7:0] THERMAL_LATCH_MASK = 8'hc0;
    localparam logic [7:0] CML_LATCH_MASK = 8'hfa;
    localparam int INPUT_OFF_LIVE_POS = 3;
    localparam int INPUT_UV_WARN_POS = 5;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic ov_fault;
        logic ov_warn;
        logic uv_warn;
        logic power_input_rail_low;
        logic internal_five_volt_rail_low;
    } itcsb_input_ev_type;

    typedef struct packed {
        logic ot_fault;
        logic ot_warn;
    } itcsb_thermal_ev_type;

    typedef struct packed {
        logic bad_command;
        logic bad_payload;
        logic pec_fail;
        logic memory_error;
        logic logic_core_error;
        logic link_error;
        logic back_channel_error;
    } itcsb_cml_ev_type;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] cmd;
        logic [7:0] data;
        logic       clear_faults;
    } itcsb_host_req_type;

endpackage : itcsb_pkg

// >>> rtl/itcsb_flag_byte.sv
`timescale 1ns/1ns
// ==========================================================
// Latched byte of flags, write-one clear
module itcsb_flag_byte #(
    parameter logic [7:0] SUPPORTED = 8'hff
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Events and clears
    input wire logic [7:0] set_i,
    input wire logic [7:0] w1c_i,
    input wire logic clear_all_i,
    // Latched value
    output logic [7:0] flags_o
);
    typedef struct packed {
        logic [7:0] flags;
    } itcsb_fb_state_type;

    itcsb_fb_state_type st_q;
    itcsb_fb_state_type st_d;

    always_comb begin
        st_d = st_q;
        if (clear_all_i) begin
            st_d.flags = itcsb_pkg::STATUS_RESET;
        end else begin
            st_d.flags = st_q.flags & ~w1c_i;
        end
        st_d.flags = (st_d.flags | set_i) & SUPPORTED;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign flags_o = st_q.flags;
endmodule : itcsb_flag_byte

// >>> rtl/itcsb_status_bank.sv
`timescale 1ns/1ns
// ==========================================================
// Input, thermal and CML status bank
module itcsb_status_bank (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Host command port
    input wire itcsb_pkg::itcsb_host_req_type req_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_miss_o,
    // Fault detectors
    input wire itcsb_pkg::itcsb_input_ev_type input_ev_i,
    input wire logic input_above_on_i,
    input wire itcsb_pkg::itcsb_thermal_ev_type thermal_ev_i,
    input wire itcsb_pkg::itcsb_cml_ev_type cml_ev_i,
    input wire logic follower_i,
    // Alert masks
    input wire logic [7:0] input_mask_i,
    input wire logic [7:0] thermal_mask_i,
    input wire logic [7:0] cml_mask_i,
    // Alert and summary
    output logic alert_req_o,
    output logic summary_cml_o,
    output logic input_off_live_bit_o
);
    typedef struct packed {
        logic [7:0] rd_data;
        logic rd_valid;
        logic rd_miss;
        logic alert;
        logic summary_cml;
        logic input_off;
        logic uv_armed;
    } itcsb_bank_state_type;

    itcsb_bank_state_type st_q;
    itcsb_bank_state_type st_d;

    logic [7:0] in_set;
    logic [7:0] th_set;
    logic [7:0] cml_set;
    logic [7:0] in_w1c;
    logic [7:0] th_w1c;
    logic [7:0] cml_w1c;
    logic [7:0] in_flags;
    logic [7:0] th_flags;
    logic [7:0] cml_flags;
    logic [7:0] in_byte;

    // ==========================================================
    // Write-one-clear decode
    function automatic logic [7:0] w1c_for(input logic [7:0] code,
                                           input itcsb_pkg::itcsb_host_req_type r);
        w1c_for = (r.wr && r.cmd == code) ? r.data : 8'h00;
    endfunction : w1c_for

    always_comb begin
        in_w1c = w1c_for(itcsb_pkg::CMD_INPUT_STATUS, req_i);
        th_w1c = w1c_for(itcsb_pkg::CMD_THERMAL_STATUS, req_i);
        cml_w1c = w1c_for(itcsb_pkg::CMD_CML_STATUS, req_i);
        // Event mapping onto bit positions
        in_set = {input_ev_i.ov_fault, input_ev_i.ov_warn,
                  input_ev_i.uv_warn & st_q.uv_armed, 5'h00};
        th_set = {thermal_ev_i.ot_fault, thermal_ev_i.ot_warn, 6'h00};
        cml_set = {cml_ev_i.bad_command, cml_ev_i.bad_payload,
                   cml_ev_i.pec_fail,
                   cml_ev_i.memory_error, cml_ev_i.logic_core_error,
                   1'b0,
                   cml_ev_i.link_error | (follower_i & cml_ev_i.back_channel_error),
                   1'b0};
    end

    // ==========================================================
    // Latched flag bytes
    itcsb_flag_byte #(.SUPPORTED(itcsb_pkg::INPUT_LATCH_MASK)) u_input (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .set_i(in_set),
        .w1c_i(in_w1c),
        .clear_all_i(req_i.clear_faults),
        .flags_o(in_flags)
    );

    itcsb_flag_byte #(.SUPPORTED(itcsb_pkg::THERMAL_LATCH_MASK)) u_thermal (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .set_i(th_set),
        .w1c_i(th_w1c),
        .clear_all_i(req_i.clear_faults),
        .flags_o(th_flags)
    );

    itcsb_flag_byte #(.SUPPORTED(itcsb_pkg::CML_LATCH_MASK)) u_cml (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .set_i(cml_set),
        .w1c_i(cml_w1c),
        .clear_all_i(req_i.clear_faults),
        .flags_o(cml_flags)
    );

    // ==========================================================
    // Read mux, live bit, alert and summary
    always_comb begin
        st_d = st_q;
        in_byte = in_flags;
        in_byte[itcsb_pkg::INPUT_OFF_LIVE_POS] = st_q.input_off;
        st_d.input_off = input_ev_i.power_input_rail_low
                       | input_ev_i.internal_five_volt_rail_low;
        if (input_above_on_i) begin
            st_d.uv_armed = 1'b1;
        end
        st_d.rd_valid = req_i.rd;
        st_d.rd_miss = 1'b0;
        if (req_i.rd) begin
            case (req_i.cmd)
                itcsb_pkg::CMD_INPUT_STATUS: begin
                    st_d.rd_data = in_byte;
                end
                itcsb_pkg::CMD_THERMAL_STATUS: begin
                    st_d.rd_data = th_flags;
                end
                itcsb_pkg::CMD_CML_STATUS: begin
                    st_d.rd_data = cml_flags;
                end
                default: begin
                    st_d.rd_data = 8'h00;
                    st_d.rd_miss = 1'b1;
                end
            endcase
        end
        // Live bit excluded from alert
        st_d.alert = |(in_flags & itcsb_pkg::INPUT_LATCH_MASK & ~input_mask_i)
                   | |(th_flags & ~thermal_mask_i)
                   | |(cml_flags & ~cml_mask_i);
        st_d.summary_cml = |cml_flags;
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st_q <= '0;
            st_q.input_off <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_o = st_q.rd_data;
    assign rd_valid_o = st_q.rd_valid;
    assign rd_miss_o = st_q.rd_miss;
    assign alert_req_o = st_q.alert;
    assign summary_cml_o = st_q.summary_cml;
    assign input_off_live_bit_o = st_q.input_off;
endmodule : itcsb_status_bank

// >>> verif/itcsb_status_bank_assertions.sv
`timescale 1ns/1ns
// ==========================================================
// Port checks of the status bank
module itcsb_status_bank_chk (
    input wire logic mclk_i, rst_i,
    input wire itcsb_pkg::itcsb_host_req_type req_i,
    input wire logic [7:0] rd_data_o, input_mask_i, thermal_mask_i, cml_mask_i,
    input wire logic rd_valid_o, rd_miss_o, alert_req_o, summary_cml_o,
    input wire logic input_off_live_bit_o,
    input wire itcsb_pkg::itcsb_thermal_ev_type thermal_ev_i,
    input wire itcsb_pkg::itcsb_cml_ev_type cml_ev_i
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence rd_of(c);
        req_i.rd && req_i.cmd == c;
    endsequence
    sequence quiet_clear;
        req_i.clear_faults && cml_ev_i == '0 ##1 cml_ev_i == '0;
    endsequence
    chk_rd_answer: assert property (req_i.rd |=> rd_valid_o)
        else $error("read not answered");
    chk_no_answer: assert property (!req_i.rd |=> !rd_valid_o)
        else $error("answer without read");
    chk_miss_zero: assert property (rd_miss_o |-> rd_data_o == 8'h00)
        else $error("unknown read not zero");
    chk_input_zero: assert property (rd_of(8'h7c) |=> (rd_data_o & 8'h17) == 8'h00)
        else $error("input spare bits set");
    chk_thermal_zero: assert property (rd_of(8'h7d) |=> rd_data_o[5:0] == 6'h00)
        else $error("thermal spare bits set");
    chk_cml_zero: assert property (rd_of(8'h7e) |=> (rd_data_o & 8'h05) == 8'h00)
        else $error("cml spare bits set");
    chk_live_reset: assert property ($fell(rst_i) |-> input_off_live_bit_o)
        else $error("live bit low after reset");
    chk_summary_clear: assert property (quiet_clear |=> !summary_cml_o)
        else $error("summary not cleared");
    chk_all_masked: assert property ((&{input_mask_i, thermal_mask_i, cml_mask_i})[*3]
        |=> !alert_req_o)
        else $error("alert while all masked");
    chk_fault_alert: assert property (thermal_ev_i.ot_fault && !thermal_mask_i[7] ##1
        !thermal_mask_i[7] |=> alert_req_o)
        else $error("fault without alert");
endmodule : itcsb_status_bank_chk
bind itcsb_status_bank itcsb_status_bank_chk i_chk (.*);

// >>> verif/itcsb_host_model.sv
`timescale 1ns/1ns
// ==========================================================
// Host side of the command port
module itcsb_host_model (
    input wire logic mclk_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_valid_i, rd_miss_i,
    output itcsb_pkg::itcsb_host_req_type req_o
);
    initial req_o = '0;
    task automatic xfer(input logic w, rd, cl, input logic [7:0] c, d, output logic [9:0] res);
        @(posedge mclk_i);
        req_o <= '{wr: w, rd: rd, cmd: c, data: d, clear_faults: cl};
        @(posedge mclk_i);
        req_o <= '0;
        @(negedge mclk_i);
        res = {rd_valid_i, rd_miss_i, rd_data_i};
    endtask : xfer
endmodule : itcsb_host_model

// >>> verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    logic mclk_i = 0, rst_i = 1, input_above_on_i = 0, follower_i = 0, lv, armed = 0;
    logic [7:0] rd_data_o, d, input_mask_i = 0, thermal_mask_i = 0, cml_mask_i = 0;
    logic rd_valid_o, rd_miss_o, alert_req_o, summary_cml_o, input_off_live_bit_o;
    itcsb_pkg::itcsb_host_req_type req_i;
    itcsb_pkg::itcsb_input_ev_type input_ev_i = 5'h02;
    itcsb_pkg::itcsb_thermal_ev_type thermal_ev_i = '0;
    itcsb_pkg::itcsb_cml_ev_type cml_ev_i = '0;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, j;
    logic [7:0] ex [3];
    logic [9:0] r;
    initial forever #20 mclk_i = ~mclk_i;
    itcsb_status_bank i_dut (.*);
    itcsb_host_model i_host (.mclk_i(mclk_i), .rd_data_i(rd_data_o), .rd_valid_i(rd_valid_o),
        .rd_miss_i(rd_miss_o), .req_o(req_i));
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_mismatch++;
            complete_run();
        end
    end
    task automatic chk(input logic [9:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic rdc(input int i);
        i_host.xfer(0, 1, 0, 8'h7c + 8'(i), 8'h00, r);
        chk(r, {2'b10, ex[i] | (i == 0 ? {4'h0, lv, 3'h0} : 8'h00)});
    endtask : rdc
    task automatic pulse(input logic [11:0] e);
        @(posedge mclk_i);
        {input_ev_i[4:2], thermal_ev_i, cml_ev_i} <= e;
        @(posedge mclk_i);
        {input_ev_i[4:2], thermal_ev_i, cml_ev_i} <= '0;
        ex[0] |= {e[11:10], e[9] & armed, 5'h00};
        ex[1] |= {e[8:7], 6'h00};
        ex[2] |= {e[6:2], 1'b0, e[1] | (e[0] & follower_i), 1'b0};
    endtask : pulse
    task automatic chk_alert();
        repeat (2) @(posedge mclk_i);
        @(negedge mclk_i);
        d = (ex[0] & ~input_mask_i) | (ex[1] & ~thermal_mask_i) | (ex[2] & ~cml_mask_i);
        chk({8'h00, alert_req_o, summary_cml_o}, {8'h00, |d, |ex[2]});
    endtask : chk_alert
    initial begin
        r = 10'($urandom(60));
        ex = '{default: 8'h00};
        lv = 1;
        repeat (5) @(posedge mclk_i);
        rst_i <= 0;
        for (int i = 0; i < 3; i++) rdc(i);
        chk_alert();
        i_host.xfer(0, 1, 0, 8'h7f, 8'h00, r);
        chk(r, 10'h300);
        pulse(12'h200);
        rdc(0);
        @(posedge mclk_i);
        input_ev_i[1:0] <= 2'b01;
        rdc(0);
        @(posedge mclk_i);
        input_ev_i[1:0] <= 2'b00;
        input_above_on_i <= 1;
        lv = 0;
        armed = 1;
        repeat (2) @(posedge mclk_i);
        rdc(0);
        chk({9'h000, input_off_live_bit_o}, 10'h000);
        $display("test reset and live done");
        for (int k = 0; k < 20; k++) begin
            @(posedge mclk_i);
            {follower_i, input_mask_i, thermal_mask_i, cml_mask_i} <= 25'($urandom);
            pulse(12'($urandom));
            chk_alert();
            for (int i = 0; i < 3; i++) rdc(i);
            j = $urandom_range(2);
            d = 8'($urandom);
            i_host.xfer(1, 0, 0, 8'h7c + 8'(j), d, r);
            ex[j] &= ~d;
            rdc(j);
        end
        $display("test random events done");
        ex = '{default: 8'h00};
        @(posedge mclk_i);
        {input_mask_i, thermal_mask_i, cml_mask_i} <= '1;
        fork
            i_host.xfer(0, 0, 1, 8'h00, 8'h00, r);
            pulse(12'h100);
        join
        for (int i = 0; i < 3; i++) rdc(i);
        chk_alert();
        $display("test clear race done");
        complete_run();
    end
endmodule : tb_top
